//--- bench/chunk_appender_tb_top.sv
// Testbench of the chunk appender: register accesses and image traffic.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ps
module chunk_appender_tb_top;
	logic clk, reset_n, avs_read, avs_write, avs_waitrequest; // Bus control
	logic [4:0] avs_address; // Register offset
	logic [31:0] avs_writedata, avs_readdata, q; // Bus data
	logic [7:0] in_data, out_data, seq_index; // Streams
	logic in_last, in_valid, in_ready, out_last, out_valid, out_ready; // Flow
	logic seq_on, hold, slow, crc_on, crc_ok; // Host and sequencer
	logic [15:0] last_crc; // Checksum of the latest payload
	int frames, nframes, miscompares, checked; // Counters

	chunk_appender i_chunk_appender (.clk(clk), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.in_data(in_data), .in_last(in_last), .in_valid(in_valid),
		.in_ready(in_ready), .out_data(out_data), .out_last(out_last),
		.out_valid(out_valid), .out_ready(out_ready), .seq_on(seq_on),
		.seq_index(seq_index));
	payload_host i_payload_host (.clk(clk), .reset_n(reset_n),
		.out_data(out_data), .out_last(out_last), .out_valid(out_valid),
		.out_ready(out_ready), .hold(hold), .slow(slow), .crc_on(crc_on),
		.crc_ok(crc_ok), .frames(frames));

	// Free-running 50 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Word comparison
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("wrong value at %0t: word %h, expected %h", $time, g, e);
		end
	endtask : chk32

	// Payload byte comparison
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("wrong value at %0t: byte %h, expected %h", $time, g, e);
		end
	endtask : chk8

	// One Avalon access; holds the request until waitrequest is seen low
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk);
		// Only the watchdog ends an answer that never comes
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		// Gap edge so the next request is not raised in the same step
		@(posedge clk);
	endtask : bus

	// Offer one image; each byte waits for in_ready
	task automatic send(input int len, input logic [7:0] base,
		input logic ck);
		crc_on <= ck;
		for (int i = 0; i < len; i++)
		begin
			in_data <= base + i[7:0];
			in_last <= (i == len - 1);
			in_valid <= 1'b1;
			@(posedge clk);
			while (in_ready !== 1'b1)
				@(posedge clk);
		end
		in_valid <= 1'b0;
		in_last <= 1'b0;
	endtask : send

	// Build the expected payload and compare it with what the host got
	task automatic check_frame(input int len, input logic [7:0] base,
		input logic idx_on, input logic [7:0] idx, input logic ck_on);
		logic [7:0] e[$];
		for (int i = 0; i < len; i++)
			e.push_back(base + i[7:0]);
		if (idx_on)
		begin
			e.push_back(8'h01);
			e.push_back(idx);
		end
		if (ck_on)
		begin
			// The checksum tag is covered, its two value bytes are not
			e.push_back(8'h02);
			last_crc = i_payload_host.crc_of(e, e.size());
			e.push_back(last_crc[15:8]);
			e.push_back(last_crc[7:0]);
		end
		// A payload that never ends is left to the watchdog
		while (frames < nframes + 1)
			@(posedge clk);
		nframes++;
		chk32(i_payload_host.frame.size(), e.size());
		for (int i = 0; i < e.size(); i++)
			chk8(i_payload_host.frame[i], e[i]);
		if (ck_on)
			chk32(crc_ok, 1);
	endtask : check_frame

	// Print counts and verdict, then stop
	task automatic report_and_stop();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	// Cuts a hang short; the tests need far fewer cycles
	initial
	begin
		#400000;
		miscompares++;
		report_and_stop();
	end

	// Main sequence
	initial
	begin
		{reset_n, avs_read, avs_write, in_last, in_valid} = 5'h00;
		{seq_on, hold, slow, crc_on} = 4'h0;
		{avs_address, avs_writedata, in_data, seq_index} = 53'h0;
		{nframes, miscompares, checked} = 0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		// Reset values and an unmapped offset
		bus(0, chunk_pkg::OFS_CTRL, 0); chk32(q, 0);
		bus(0, chunk_pkg::OFS_SELECT, 0); chk32(q, 0);
		bus(0, chunk_pkg::OFS_ENABLE, 0); chk32(q, 0);
		bus(0, chunk_pkg::OFS_STATUS, 0); chk32(q, 0);
		bus(0, 5'h10, 0); chk32(q, 0);
		// Enable refused while chunk mode is off, then index enable refused while the sequencer is off
		bus(1, chunk_pkg::OFS_ENABLE, 1);
		bus(0, chunk_pkg::OFS_ENABLE, 0); chk32(q, 0);
		bus(1, chunk_pkg::OFS_CTRL, 1);
		bus(1, chunk_pkg::OFS_SELECT, {30'h0, chunk_pkg::TYPE_INDEX});
		bus(1, chunk_pkg::OFS_ENABLE, 1);
		bus(0, chunk_pkg::OFS_ENABLE, 0); chk32(q, 0);
		seq_on <= 1'b1;
		bus(1, chunk_pkg::OFS_ENABLE, 1);
		bus(0, chunk_pkg::OFS_ENABLE, 0); chk32(q, 1);
		bus(1, chunk_pkg::OFS_SELECT, {30'h0, chunk_pkg::TYPE_CRC});
		bus(1, chunk_pkg::OFS_ENABLE, 1);
		bus(0, chunk_pkg::OFS_STATUS, 0); chk32(q, 32'h0007_0000);
		// Both chunks on a one-byte image
		seq_index <= 8'h05;
		send(1, 8'haa, 1);
		check_frame(1, 8'haa, 1, 8'h05, 1);
		bus(0, chunk_pkg::OFS_STATUS, 0);
		chk32(q, {16'h0007, last_crc});
		// Same image twice with a slow host gives the same checksum
		slow <= 1'b1;
		for (int r = 0; r < 2; r++)
		begin
			send(5, 8'h10, 1);
			check_frame(5, 8'h10, 1, 8'h05, 1);
		end
		slow <= 1'b0;
		// Host stalls until the buffer refuses, then drains it all
		seq_index <= 8'h07;
		hold <= 1'b1;
		fork
			send(12, 8'h40, 1);
		join_none
		repeat (20) @(posedge clk);
		chk32(in_ready, 0);
		hold <= 1'b0;
		wait fork;
		check_frame(12, 8'h40, 1, 8'h07, 1);
		// Index off: checksum alone still ends the payload
		bus(1, chunk_pkg::OFS_SELECT, {30'h0, chunk_pkg::TYPE_INDEX});
		bus(1, chunk_pkg::OFS_ENABLE, 0);
		send(3, 8'h20, 1);
		check_frame(3, 8'h20, 0, 8'h00, 1);
		// Chunk mode off clears every enable; bare image passes
		bus(1, chunk_pkg::OFS_CTRL, 0);
		bus(1, chunk_pkg::OFS_SELECT, {30'h0, chunk_pkg::TYPE_CRC});
		bus(0, chunk_pkg::OFS_ENABLE, 0); chk32(q, 0);
		send(2, 8'h30, 0);
		check_frame(2, 8'h30, 0, 8'h00, 0);
		report_and_stop();
	end
endmodule : chunk_appender_tb_top

//--- bench/payload_host.sv
// Far-side host: takes the payload stream and checks its checksum.
// Assumes the block's clock and an active-low reset.
`timescale 1ns/1ps
module payload_host (
	input wire logic clk, // System clock
	input wire logic reset_n, // Reset, active low
	input wire logic [7:0] out_data, // Payload byte
	input wire logic out_last, // Last payload byte
	input wire logic out_valid, // Byte offered
	output logic out_ready, // Host takes the byte
	input wire logic hold, // Stop taking bytes
	input wire logic slow, // Take every other cycle
	input wire logic crc_on, // Payload ends in a checksum
	output logic crc_ok, // Last payload checksum matched
	output int frames // Payloads received
);
	logic [7:0] buf_q[$]; // Payload being received
	logic [7:0] frame[$]; // Last complete payload
	logic tick_r; // Alternates for slow mode

	// Checksum over the first n bytes, MSB first, no final inversion
	function automatic logic [15:0] crc_of(input logic [7:0] b[$],
		input int n);
		logic [15:0] c;
		c = 16'h0000;
		for (int i = 0; i < n; i++)
		begin
			c = c ^ {b[i], 8'h00};
			for (int k = 0; k < 8; k++)
				c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
		end
		return c;
	endfunction : crc_of

	// Collect bytes; judge a payload when its last byte arrives
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			out_ready <= 1'b0;
			tick_r <= 1'b0;
			crc_ok <= 1'b0;
			frames <= 0;
			buf_q.delete();
		end
		else
		begin
			tick_r <= !tick_r;
			// Stalls are the host's right, so the block must hold its bytes
			out_ready <= !hold && (!slow || tick_r);
			if (out_valid && out_ready)
			begin
				buf_q.push_back(out_data);
				if (out_last)
				begin
					frame = buf_q;
					// High on a match with crc_on set, low otherwise
					crc_ok <= crc_on && frame.size() >= 2 &&
						crc_of(frame, frame.size() - 2) ===
						{frame[frame.size()-2], frame[frame.size()-1]};
					frames <= frames + 1;
					buf_q.delete();
				end
			end
		end
	end
endmodule : payload_host

//--- verilog/byte_fifo.sv
// Small synchronous FIFO with registered flags.
// Assumes one clock and an already synchronised active-low reset.
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Synchronised reset
	stream_if.snk wr, // Filling side
	stream_if.src rd // Draining side
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // Storage words
	logic [PW-1:0] wp_r, wp_nxt; // Write pointer
	logic [PW-1:0] rp_r, rp_nxt; // Read pointer
	logic [CW-1:0] cnt_r, cnt_nxt; // Fill level
	logic push, pop; // Handshakes this cycle
	logic rdy_r, vld_r; // Registered flags

	assign push = wr.valid && rdy_r;
	assign pop = vld_r && rd.ready;
	assign wr.ready = rdy_r;
	assign rd.valid = vld_r;
	assign rd.data = mem[rp_r];

	// Pointer and level arithmetic; wrap is explicit for odd depths
	always_comb
	begin
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (push)
			wp_nxt = (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
		if (pop)
			rp_nxt = (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
		if (push && !pop)
			cnt_nxt = cnt_r + 1'b1;
		else if (pop && !push)
			cnt_nxt = cnt_r - 1'b1;
	end

	// Flags come from the next level so they never lag a cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			rdy_r <= 1'b0;
			vld_r <= 1'b0;
		end
		else
		begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			rdy_r <= cnt_nxt != FULL;
			vld_r <= cnt_nxt != '0;
		end
	end

	// Storage has no reset; flags guard every read
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wp_r] <= wr.data;
	end
endmodule : byte_fifo

//--- verilog/chunk_appender.sv
// Image chunk appender: passes image bytes and appends an index chunk
// and a trailing checksum chunk. Registers on Avalon-MM.
// Assumes image bytes and sequencer inputs share clk.
`timescale 1ns/1ps
module chunk_appender (
	input wire logic clk, // 50 MHz clock
	input wire logic reset_n, // Async reset, active low
	input wire logic [4:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall
	input wire logic [7:0] in_data, // Image byte
	input wire logic in_last, // Last byte of image
	input wire logic in_valid, // Image byte offered
	output logic in_ready, // Buffer can take a byte
	output logic [7:0] out_data, // Payload byte
	output logic out_last, // Last byte of payload
	output logic out_valid, // Payload byte offered
	input wire logic out_ready, // Sink takes the byte
	input wire logic seq_on, // Sequencer enabled
	input wire logic [7:0] seq_index // Active sequence set
);
	logic [1:0] rst_q_r; // Reset release synchroniser
	logic rst_n; // Synchronised reset
	// Register state
	logic active_r, active_nxt; // Chunk mode
	logic [1:0] sel_r, sel_nxt; // Chunk type select
	logic [1:0] en_r, en_nxt; // [0] checksum, [1] index
	logic wait_r, wait_nxt; // Waitrequest
	logic [31:0] rdata_r, rdata_nxt; // Read data
	logic wr_take; // Write taken this cycle
	logic sel_on; // Enable of selected type
	// Stream state
	chunk_pkg::out_state_t st_r, st_nxt; // Output sequencer
	logic [15:0] crc_r, crc_nxt; // Running checksum
	logic [15:0] crc_step; // Checksum after byte
	logic [15:0] sent_r, sent_nxt; // Last checksum sent
	logic [7:0] idx_r, idx_nxt; // Captured set index
	logic sof_r, sof_nxt; // Next byte starts image
	logic crc_pend_r, crc_pend_nxt; // Checksum chunk due
	logic [7:0] emit_byte; // Byte for this state
	logic [7:0] odata_r, odata_nxt; // Output byte
	logic olast_r, olast_nxt; // Output last flag
	logic ovalid_r, ovalid_nxt; // Output valid
	logic adv; // Output slot free
	logic pop; // Image byte taken

	stream_if #(.W(chunk_pkg::FIFO_WIDTH)) in_s ();
	stream_if #(.W(chunk_pkg::FIFO_WIDTH)) buf_s ();

	// Reset release: asserted at once, removed after two edges
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rst_q_r <= 2'h0;
		else
			rst_q_r <= {rst_q_r[0], 1'b1};
	end
	assign rst_n = rst_q_r[1];

	// Image bytes enter through the buffer; its ready is a register
	assign in_s.data = {in_last, in_data};
	assign in_s.valid = in_valid;
	assign in_ready = in_s.ready;

	byte_fifo #(
		.WIDTH(chunk_pkg::FIFO_WIDTH),
		.DEPTH(chunk_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.wr(in_s),
		.rd(buf_s)
	);

	// The buffer drains only while image data is being sent
	assign adv = !ovalid_r || out_ready;
	assign buf_s.ready = (st_r == chunk_pkg::ST_DATA) && adv;
	assign pop = buf_s.valid && buf_s.ready;

	// Register access: one wait cycle, then the answer
	assign wr_take = avs_write && !wait_r;
	assign sel_on = (sel_r == chunk_pkg::TYPE_CRC) ? en_r[0] :
		(sel_r == chunk_pkg::TYPE_INDEX) ? en_r[1] : 1'b0;

	// Register next values; unmapped reads return zero
	always_comb
	begin
		active_nxt = active_r;
		sel_nxt = sel_r;
		en_nxt = en_r;
		wait_nxt = !((avs_read || avs_write) && wait_r);
		rdata_nxt = rdata_r;
		if (avs_read && wait_r)
		begin
			unique case (avs_address)
				chunk_pkg::OFS_CTRL:
					rdata_nxt = {31'h0, active_r};
				chunk_pkg::OFS_SELECT:
					rdata_nxt = {30'h0, sel_r};
				chunk_pkg::OFS_ENABLE:
					rdata_nxt = {31'h0, sel_on};
				chunk_pkg::OFS_STATUS:
					rdata_nxt = {13'h0, en_r, seq_on, sent_r};
				default:
					rdata_nxt = 32'h0;
			endcase
		end
		if (wr_take)
		begin
			unique case (avs_address)
				chunk_pkg::OFS_CTRL:
				begin
					active_nxt = avs_writedata[chunk_pkg::BIT_ACTIVE];
					// Leaving chunk mode drops every chunk type
					if (!avs_writedata[chunk_pkg::BIT_ACTIVE])
						en_nxt = 2'h0;
				end
				chunk_pkg::OFS_SELECT:
					sel_nxt = avs_writedata[1:0];
				chunk_pkg::OFS_ENABLE:
				begin
					// Without chunk mode the write is ignored
					if (active_r)
					begin
						if (sel_r == chunk_pkg::TYPE_CRC)
							en_nxt[0] = avs_writedata[chunk_pkg::BIT_ON];
						else if (sel_r == chunk_pkg::TYPE_INDEX &&
							(seq_on || !avs_writedata[chunk_pkg::BIT_ON]))
							en_nxt[1] = avs_writedata[chunk_pkg::BIT_ON];
					end
				end
				default:
					active_nxt = active_r; // Unmapped write ignored
			endcase
		end
	end

	// Register file flip-flops
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			active_r <= 1'b0;
			sel_r <= chunk_pkg::SELECT_RST;
			en_r <= chunk_pkg::ENABLE_RST;
			wait_r <= 1'b1;
			rdata_r <= 32'h0;
		end
		else
		begin
			active_r <= active_nxt;
			sel_r <= sel_nxt;
			en_r <= en_nxt;
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign avs_waitrequest = wait_r;
	assign avs_readdata = rdata_r;

	// Byte that the current state would send
	always_comb
	begin
		unique case (st_r)
			chunk_pkg::ST_DATA: emit_byte = buf_s.data[7:0];
			chunk_pkg::ST_IDX_TAG: emit_byte = chunk_pkg::TAG_INDEX;
			chunk_pkg::ST_IDX_VAL: emit_byte = idx_r;
			chunk_pkg::ST_CRC_TAG: emit_byte = chunk_pkg::TAG_CRC;
			chunk_pkg::ST_CRC_HI: emit_byte = crc_r[15:8];
			chunk_pkg::ST_CRC_LO: emit_byte = crc_r[7:0];
			default: emit_byte = 8'h00;
		endcase
	end

	crc16_byte u_crc (
		.crc_in(crc_r),
		.din(emit_byte),
		.crc_out(crc_step)
	);

	// Output sequencer: image bytes, then index chunk, then checksum
	always_comb
	begin
		st_nxt = st_r;
		crc_nxt = crc_r;
		sent_nxt = sent_r;
		idx_nxt = idx_r;
		sof_nxt = sof_r;
		crc_pend_nxt = crc_pend_r;
		odata_nxt = odata_r;
		olast_nxt = olast_r;
		ovalid_nxt = ovalid_r;
		if (adv)
		begin
			ovalid_nxt = 1'b0;
			olast_nxt = 1'b0;
		end
		unique case (st_r)
			chunk_pkg::ST_DATA:
			begin
				if (pop)
				begin
					ovalid_nxt = 1'b1;
					odata_nxt = emit_byte;
					crc_nxt = crc_step;
					sof_nxt = buf_s.data[8];
					// Set index belongs to the frame being sent
					if (sof_r)
						idx_nxt = seq_index;
					if (buf_s.data[8])
					begin
						// Chunk choice is frozen at the end of the image
						crc_pend_nxt = en_r[0];
						if (en_r[1])
							st_nxt = chunk_pkg::ST_IDX_TAG;
						else if (en_r[0])
							st_nxt = chunk_pkg::ST_CRC_TAG;
						else
						begin
							olast_nxt = 1'b1;
							crc_nxt = chunk_pkg::CRC_INIT;
						end
					end
				end
			end
			chunk_pkg::ST_IDX_TAG:
			begin
				if (adv)
				begin
					ovalid_nxt = 1'b1;
					odata_nxt = emit_byte;
					crc_nxt = crc_step;
					st_nxt = chunk_pkg::ST_IDX_VAL;
				end
			end
			chunk_pkg::ST_IDX_VAL:
			begin
				if (adv)
				begin
					ovalid_nxt = 1'b1;
					odata_nxt = emit_byte;
					crc_nxt = crc_step;
					if (crc_pend_r)
						st_nxt = chunk_pkg::ST_CRC_TAG;
					else
					begin
						olast_nxt = 1'b1;
						crc_nxt = chunk_pkg::CRC_INIT;
						st_nxt = chunk_pkg::ST_DATA;
					end
				end
			end
			chunk_pkg::ST_CRC_TAG:
			begin
				if (adv)
				begin
					ovalid_nxt = 1'b1;
					odata_nxt = emit_byte;
					crc_nxt = crc_step;
					st_nxt = chunk_pkg::ST_CRC_HI;
				end
			end
			chunk_pkg::ST_CRC_HI:
			begin
				// Checksum bytes are not folded into the checksum
				if (adv)
				begin
					ovalid_nxt = 1'b1;
					odata_nxt = emit_byte;
					st_nxt = chunk_pkg::ST_CRC_LO;
				end
			end
			chunk_pkg::ST_CRC_LO:
			begin
				if (adv)
				begin
					ovalid_nxt = 1'b1;
					odata_nxt = emit_byte;
					olast_nxt = 1'b1;
					sent_nxt = crc_r;
					crc_nxt = chunk_pkg::CRC_INIT;
					st_nxt = chunk_pkg::ST_DATA;
				end
			end
			default:
				st_nxt = chunk_pkg::ST_DATA; // Illegal code recovers
		endcase
	end

	// Stream flip-flops
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r <= chunk_pkg::ST_DATA;
			crc_r <= chunk_pkg::CRC_INIT;
			sent_r <= chunk_pkg::CRC_INIT;
			idx_r <= 8'h00;
			sof_r <= 1'b1;
			crc_pend_r <= 1'b0;
			odata_r <= 8'h00;
			olast_r <= 1'b0;
			ovalid_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			crc_r <= crc_nxt;
			sent_r <= sent_nxt;
			idx_r <= idx_nxt;
			sof_r <= sof_nxt;
			crc_pend_r <= crc_pend_nxt;
			odata_r <= odata_nxt;
			olast_r <= olast_nxt;
			ovalid_r <= ovalid_nxt;
		end
	end
	assign out_data = odata_r;
	assign out_last = olast_r;
	assign out_valid = ovalid_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence crc_tail_s;
		st_r == chunk_pkg::ST_CRC_HI && adv ##1
			st_r == chunk_pkg::ST_CRC_LO && adv;
	endsequence
	sequence enable_wr_s;
		wr_take && avs_address == chunk_pkg::OFS_ENABLE;
	endsequence

	crc_hi_out_a: assert property (
		st_r == chunk_pkg::ST_CRC_HI && adv |=>
			ovalid_r && odata_r == $past(crc_r[15:8]))
		else $error("checksum high byte wrong");
	crc_frozen_a: assert property (
		crc_tail_s |-> crc_r == $past(crc_r))
		else $error("checksum changed on its own bytes");
	crc_last_a: assert property (
		crc_tail_s |=> olast_r && ovalid_r && odata_r == $past(crc_r[7:0]))
		else $error("checksum chunk not final");
	refuse_off_a: assert property (
		enable_wr_s and !active_r |=> en_r == $past(en_r))
		else $error("enable taken without chunk mode");
	mode_off_a: assert property (
		!active_r |-> en_r == 2'h0)
		else $error("chunk type on while mode off");
	crc_enable_a: assert property (
		enable_wr_s and active_r and sel_r == chunk_pkg::TYPE_CRC |=>
			en_r[0] == $past(avs_writedata[0]))
		else $error("checksum enable not stored");
	idx_value_a: assert property (
		st_r == chunk_pkg::ST_IDX_TAG && adv ##1 adv |=>
			odata_r == $past(idx_r) && ovalid_r)
		else $error("index chunk value wrong");
	idx_gate_a: assert property (
		$rose(en_r[1]) |-> $past(seq_on))
		else $error("index enabled without sequencer");
	crc_restart_a: assert property (
		ovalid_r && olast_r && $past(adv) && $changed(odata_r)
			|-> crc_r == chunk_pkg::CRC_INIT)
		else $error("checksum not restarted");
endmodule : chunk_appender

//--- verilog/chunk_pkg.sv
// Constants shared by the chunk appender and its helpers.
// Assumes a 50 MHz clock and 32-bit Avalon-MM register access.
// What this block does
// - Enabled checksum chunk appended to every image
// - Checksum covers image, chunks and its own tag, not its two value bytes
// - Checksum chunk always ends the payload
// - Chunk enables refused unless chunk mode active
// - Chunk mode off disables every chunk type
// - Selected type plus enable true turns chunk on
// - Index chunk carries the frame's sequence set
// - Index chunk enabled only with sequencer on
package chunk_pkg;
	// Register byte offsets
	localparam logic [4:0] OFS_CTRL = 5'h00; // Chunk mode
	localparam logic [4:0] OFS_SELECT = 5'h04; // Chunk type select
	localparam logic [4:0] OFS_ENABLE = 5'h08; // Enable of selection
	localparam logic [4:0] OFS_STATUS = 5'h0c; // Block state
	// Field positions
	localparam int BIT_ACTIVE = 0; // In CTRL
	localparam int BIT_ON = 0; // In ENABLE
	localparam int BIT_STAT_SEQ = 16; // In STATUS
	localparam int BIT_STAT_EN = 17; // Two enables in STATUS
	// Chunk type codes for the selector
	localparam logic [1:0] TYPE_CRC = 2'h0;
	localparam logic [1:0] TYPE_INDEX = 2'h1;
	// Chunk tag bytes placed ahead of each chunk body
	localparam logic [7:0] TAG_INDEX = 8'h01;
	localparam logic [7:0] TAG_CRC = 8'h02;
	// Checksum parameters
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	// Reset values
	localparam logic [1:0] SELECT_RST = 2'h0;
	localparam logic [1:0] ENABLE_RST = 2'h0;
	// Depth and width of the input buffer
	localparam int FIFO_DEPTH = 4;
	localparam int FIFO_WIDTH = 9;
	// Output sequencer states, one-hot
	typedef enum logic [5:0] {
		ST_DATA = 6'h01,
		ST_IDX_TAG = 6'h02,
		ST_IDX_VAL = 6'h04,
		ST_CRC_TAG = 6'h08,
		ST_CRC_HI = 6'h10,
		ST_CRC_LO = 6'h20
	} out_state_t;
endpackage : chunk_pkg

//--- verilog/crc16_byte.sv
// One-byte step of the 16-bit checksum, purely combinational.
// Assumes the caller holds the running value in its own register.
`timescale 1ns/1ps
module crc16_byte (
	input wire logic [15:0] crc_in, // Running checksum
	input wire logic [7:0] din, // Byte to fold in
	output logic [15:0] crc_out // Checksum after the byte
);
	// Shift MSB first, no reflection, no final inversion
	always_comb
	begin
		logic [15:0] c;
		logic fb;
		c = crc_in;
		fb = 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			fb = c[15] ^ din[i];
			c = {c[14:0], 1'b0} ^ (fb ? chunk_pkg::CRC_POLY : 16'h0000);
		end
		crc_out = c;
	end
endmodule : crc16_byte

//--- verilog/stream_if.sv
// Valid/ready byte stream between the appender's own modules.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface stream_if #(parameter int W = 9);
	logic [W-1:0] data; // Payload
	logic valid; // Source offers data
	logic ready; // Sink takes data
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : stream_if
